// ===== hw/sdcd_regs.svh
`ifndef SDCD_REGS_SVH
`define SDCD_REGS_SVH
// ----------------------------------------
// Command codes on {cs_n, ras_n, cas_n, we_n}
// ----------------------------------------
`define SDCD_CODE_NOP 4'h7
`define SDCD_CODE_ACT 4'h3
`define SDCD_CODE_PRE 4'h2
`define SDCD_CODE_RD 4'h5
`define SDCD_CODE_WR 4'h4
`define SDCD_CODE_MRS 4'h0
`define SDCD_CODE_REF 4'h1
`define SDCD_CODE_BST 4'h6
// ----------------------------------------
// Widths and reset values
// ----------------------------------------
`define SDCD_BANKS 4
`define SDCD_BANK_RST 4'h0
`define SDCD_SYNC_RST 8'h00
`endif

// ===== hw/sdcd_pkg.sv
package sdcd_pkg;
   typedef enum logic [2:0] {
      SDCD_ST_NORMAL = 3'b000,
      SDCD_ST_SUSPEND = 3'b001,
      SDCD_ST_POWERDN = 3'b010,
      SDCD_ST_SELFREF = 3'b011
   } sdcd_state_t;
   typedef enum logic [3:0] {
      SDCD_CMD_NONE = 4'h0,
      SDCD_CMD_NOP = 4'h1,
      SDCD_CMD_ACT = 4'h2,
      SDCD_CMD_PRE = 4'h3,
      SDCD_CMD_PREALL = 4'h4,
      SDCD_CMD_RD = 4'h5,
      SDCD_CMD_RDA = 4'h6,
      SDCD_CMD_WR = 4'h7,
      SDCD_CMD_WRA = 4'h8,
      SDCD_CMD_MRS = 4'h9,
      SDCD_CMD_REF = 4'hA,
      SDCD_CMD_BST = 4'hB,
      SDCD_CMD_SREF = 4'hC
   } sdcd_cmd_t;
endpackage

// ===== hw/sdcd_sync.sv
`timescale 1ns/1ps
// ----------------------------------------
// Two-stage input synchroniser
// ----------------------------------------
module sdcd_sync #(
   parameter int WIDTH = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] meta;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta <= '0;
         q_o <= '0;
      end else begin
         meta <= d_i;
         q_o <= meta;
      end
   end
endmodule // sdcd_sync

// ===== hw/sdcd_decode.sv
`timescale 1ns/1ps
`include "sdcd_regs.svh"
// Operation
// R1 - Controller sends no-operation when idle.
// R2 - Select low, strobes high decodes no-operation.
// R3 - No-operation never ends running burst.
// R4 - Select high is deselect, strobes ignored.
// R5 - Controller holds clock gate high normally.
// R6 - Gate low with bank active suspends.
// R7 - Suspend begins one clock after sampling.
// R8 - Commands ignored while suspended.
// R9 - Suspend exits one clock after gate high.
// R10 - Inputs captured on rising edges only.
// R11 - Decode uses current and previous gate.
// R12 - Read or write, flag selects auto-precharge.
// R13 - Controller accesses only active banks.
// R14 - Activate, mode set, refresh need idle.
// R15 - Burst stop only during full-page burst.
// R16 - Suspend entry ignores all other pins; here a refresh code with no bank open gives self refresh.
// R17 - Power-down entry/exit with deselect or nop.
// R18 - Power-down request in burst suspends instead.
// R19 - Precharge closes one or all banks.
// R20 - Self refresh entry, gate held low.
// R21 - Controller sends nop after power-down exit.
// R22 - Byte mask gates write and output drive.
// R23 - Undefined combinations change nothing.
module sdcd_decode
   import sdcd_pkg::*;
#(
   parameter int BANKS = `SDCD_BANKS
) (
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic CHIP_SELECT_N_I,
   input wire logic ROW_STROBE_N_I,
   input wire logic COLUMN_STROBE_N_I,
   input wire logic WRITE_STROBE_N_I,
   input wire logic CLOCK_GATE_IN_I,
   input wire logic BANK_SEL_0_I,
   input wire logic BANK_SEL_1_I,
   input wire logic PRECHARGE_FLAG_ADDR_I,
   input wire logic BYTE_MASK_I,
   input wire logic BURST_ACTIVE_I,
   input wire logic FULL_PAGE_I,
   output sdcd_cmd_t CMD_O,
   output logic [1:0] CMD_BANK_O,
   output logic [3:0] BANK_OPEN_O,
   output sdcd_state_t STATE_O,
   output logic RUN_O,
   output logic DATA_EN_O
);
   // ----------------------------------------
   // Pin capture
   // ----------------------------------------
   // Pins cross into this clock through two stages; the extra latency is
   // uniform across every pin so command alignment is preserved.
   logic [7:0] pins;
   logic cke_prev;
   logic burst_s;
   logic fullpg_s;
   // R10 rising-edge capture
   sdcd_sync #(.WIDTH(8)) u_sync_pins (
      .clk_i(CLK_I),
      .rst_i(RST_I),
      .d_i({CHIP_SELECT_N_I, ROW_STROBE_N_I, COLUMN_STROBE_N_I, WRITE_STROBE_N_I,
            CLOCK_GATE_IN_I, BANK_SEL_1_I, BANK_SEL_0_I, PRECHARGE_FLAG_ADDR_I}),
      .q_o(pins)
   );
   sdcd_sync #(.WIDTH(2)) u_sync_misc (
      .clk_i(CLK_I),
      .rst_i(RST_I),
      .d_i({BURST_ACTIVE_I, FULL_PAGE_I}),
      .q_o({burst_s, fullpg_s})
   );
   // The byte mask is a pin too, so it gets the same two stages as the command pins.
   logic [1:0] mask_pipe;
   wire [3:0] code = pins[7:4];
   wire cke_now = pins[3];
   wire [1:0] bank = pins[2:1];
   wire a10 = pins[0];
   wire cs_n = pins[7];

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   sdcd_state_t state;
   logic [3:0] bank_open;
   wire any_open = |bank_open;
   wire idle = ~any_open;
   wire bank_is_open = bank_open[bank];
   // R11 gate history decode
   wire cke_hh = cke_prev & cke_now;
   wire cke_fall = cke_prev & ~cke_now;
   wire cke_rise = ~cke_prev & cke_now;
   // R2 no-operation code
   wire is_nop = ~cs_n & (code == `SDCD_CODE_NOP);
   // R4 deselect ignores strobes
   wire is_quiet = cs_n | is_nop;
   wire normal = (state == SDCD_ST_NORMAL);
   // R16 suspend entry, pins ignored
   // R18 burst forces suspend
   wire go_suspend = normal & cke_fall & (any_open | burst_s);
   // R17 power-down entry
   wire go_powerdn = normal & cke_fall & idle & ~burst_s & is_quiet;
   // R20 self refresh entry
   wire go_selfref = normal & cke_fall & idle & (code == `SDCD_CODE_REF);
   wire cmd_ok = normal & cke_prev & ~cs_n;

   function automatic logic [3:0] onehot(input logic [1:0] b);
      onehot = 4'h1 << b;
   endfunction

   logic [3:0] next_cmd;
   logic [3:0] next_open;
   always_comb begin
      next_cmd = SDCD_CMD_NONE;
      next_open = bank_open;
      if (normal & cke_prev & is_nop) begin
         // R3 nop keeps burst
         next_cmd = SDCD_CMD_NOP;
      end else if (cmd_ok) begin
         unique case (code)
            // R14 idle-only commands
            `SDCD_CODE_ACT: if (~bank_is_open) begin
               next_cmd = SDCD_CMD_ACT;
               next_open = bank_open | onehot(bank);
            end
            `SDCD_CODE_MRS: if (idle) next_cmd = SDCD_CMD_MRS;
            `SDCD_CODE_REF: if (idle & cke_hh) next_cmd = SDCD_CMD_REF;
            // R19 precharge one or all
            `SDCD_CODE_PRE: begin
               next_cmd = a10 ? SDCD_CMD_PREALL : SDCD_CMD_PRE;
               next_open = a10 ? `SDCD_BANK_RST : (bank_open & ~onehot(bank));
            end
            // R12 read or write select
            `SDCD_CODE_RD: if (bank_is_open) next_cmd = a10 ? SDCD_CMD_RDA : SDCD_CMD_RD;
            `SDCD_CODE_WR: if (bank_is_open) next_cmd = a10 ? SDCD_CMD_WRA : SDCD_CMD_WR;
            // R15 burst stop in full page
            `SDCD_CODE_BST: if (burst_s & fullpg_s) next_cmd = SDCD_CMD_BST;
            // R23 undefined has no effect
            default: next_cmd = SDCD_CMD_NONE;
         endcase
      end
   end

   // ----------------------------------------
   // State machine
   // ----------------------------------------
   sdcd_state_t next_state;
   always_comb begin
      next_state = state;
      unique case (state)
         // R6 enter clock suspend
         SDCD_ST_NORMAL: begin
            if (go_selfref) next_state = SDCD_ST_SELFREF;
            else if (go_suspend) next_state = SDCD_ST_SUSPEND;
            else if (go_powerdn) next_state = SDCD_ST_POWERDN;
         end
         // R9 leave suspend on gate high
         SDCD_ST_SUSPEND: if (cke_rise) next_state = SDCD_ST_NORMAL;
         // R17 exit with quiet bus
         SDCD_ST_POWERDN: if (cke_rise & is_quiet) next_state = SDCD_ST_NORMAL;
         SDCD_ST_SELFREF: if (cke_now) next_state = SDCD_ST_NORMAL;
         default: next_state = SDCD_ST_NORMAL;
      endcase
   end

   // R22 mask gates data
   wire next_data_en = any_open & ~mask_pipe[1] & normal;

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         cke_prev <= 1'b0;
         state <= SDCD_ST_NORMAL;
         bank_open <= `SDCD_BANK_RST;
         mask_pipe <= 2'h0;
         CMD_O <= SDCD_CMD_NONE;
         CMD_BANK_O <= 2'h0;
         BANK_OPEN_O <= `SDCD_BANK_RST;
         STATE_O <= SDCD_ST_NORMAL;
         RUN_O <= 1'b1;
         DATA_EN_O <= 1'b0;
      end else begin
         cke_prev <= cke_now;
         mask_pipe <= {mask_pipe[0], BYTE_MASK_I};
         state <= next_state;
         // R8 commands ignored while suspended
         bank_open <= next_open;
         CMD_O <= sdcd_cmd_t'(next_cmd);
         CMD_BANK_O <= bank;
         BANK_OPEN_O <= next_open;
         STATE_O <= next_state;
         // R7 suspend one clock later
         RUN_O <= (next_state == SDCD_ST_NORMAL);
         DATA_EN_O <= next_data_en;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   AST_NOP_DECODE: assert property (@(posedge CLK_I) disable iff (RST_I) // R2
      (normal && cke_prev && is_nop) |=> (CMD_O == SDCD_CMD_NOP))
      else $error("nop not decoded");
   AST_DESELECT: assert property (@(posedge CLK_I) disable iff (RST_I) // R4
      cs_n |=> (CMD_O == SDCD_CMD_NONE) && $stable(BANK_OPEN_O))
      else $error("deselect had effect");
   AST_SUSP_ENTRY: assert property (@(posedge CLK_I) disable iff (RST_I) // R6
      (normal && cke_fall && any_open) |=> (STATE_O == SDCD_ST_SUSPEND) && !RUN_O)
      else $error("suspend not entered");
   AST_SUSP_IGNORE: assert property (@(posedge CLK_I) disable iff (RST_I) // R8
      (state == SDCD_ST_SUSPEND) |=> (CMD_O == SDCD_CMD_NONE) && $stable(BANK_OPEN_O))
      else $error("command in suspend");
   AST_SUSP_EXIT: assert property (@(posedge CLK_I) disable iff (RST_I) // R9
      (state == SDCD_ST_SUSPEND && cke_rise) |=> RUN_O ##1 (state == SDCD_ST_NORMAL))
      else $error("suspend exit late");
   AST_READ_AP: assert property (@(posedge CLK_I) disable iff (RST_I) // R12
      (cmd_ok && code == `SDCD_CODE_RD && bank_is_open && a10) |=> CMD_O == SDCD_CMD_RDA)
      else $error("read autoprecharge lost");
   AST_PRE_ALL: assert property (@(posedge CLK_I) disable iff (RST_I) // R19
      (cmd_ok && code == `SDCD_CODE_PRE && a10) |=> BANK_OPEN_O == 4'h0)
      else $error("precharge all failed");
   AST_PD_ENTRY: assert property (@(posedge CLK_I) disable iff (RST_I) // R17
      (normal && cke_fall && idle && cs_n && !burst_s) |=> STATE_O == SDCD_ST_POWERDN)
      else $error("power-down not entered");
   AST_BURST_SUSP: assert property (@(posedge CLK_I) disable iff (RST_I) // R18
      (normal && cke_fall && idle && is_quiet && burst_s) |=> STATE_O == SDCD_ST_SUSPEND)
      else $error("burst power-down did not suspend");
   AST_MASK: assert property (@(posedge CLK_I) disable iff (RST_I) // R22
      (mask_pipe[1]) |=> !DATA_EN_O)
      else $error("mask ignored");
endmodule // sdcd_decode

// ===== tb/sdcd_ctrl_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Controller side model
// ----------------------------------------
module sdcd_ctrl_model (
   input wire logic [3:0] code_i,
   input wire logic gate_i,
   output logic [3:0] pins_o,
   output logic gate_o
);
   assign pins_o = code_i;
   assign gate_o = gate_i;
endmodule // sdcd_ctrl_model

// ===== tb/test_sdram_command_decode.sv
`timescale 1ns/1ps
`include "sdcd_regs.svh"
module test_sdram_command_decode
   import sdcd_pkg::*;
;
   // ----------------------------------------
   // Signals and clock
   // ----------------------------------------
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] code = `SDCD_CODE_NOP;
   logic gate = 1'b1;
   logic [1:0] bank = 2'h0;
   logic flag = 1'b0;
   logic mask = 1'b1;
   logic burst = 1'b0;
   logic fp = 1'b0;
   logic [3:0] pins;
   logic gw;
   sdcd_cmd_t cmd;
   logic [1:0] cbank;
   sdcd_state_t st;
   logic [3:0] open;
   logic run;
   logic den;
   int num_errors = 0;
   int total_checks = 0;
   always #2.5 clk = ~clk;
   sdcd_ctrl_model ctl (.code_i(code), .gate_i(gate), .pins_o(pins), .gate_o(gw));
   sdcd_decode dut (
      .CLK_I(clk),
      .RST_I(rst),
      .CHIP_SELECT_N_I(pins[3]),
      .ROW_STROBE_N_I(pins[2]),
      .COLUMN_STROBE_N_I(pins[1]),
      .WRITE_STROBE_N_I(pins[0]),
      .CLOCK_GATE_IN_I(gw),
      .BANK_SEL_0_I(bank[0]),
      .BANK_SEL_1_I(bank[1]),
      .PRECHARGE_FLAG_ADDR_I(flag),
      .BYTE_MASK_I(mask),
      .BURST_ACTIVE_I(burst),
      .FULL_PAGE_I(fp),
      .CMD_O(cmd),
      .CMD_BANK_O(cbank),
      .BANK_OPEN_O(open),
      .STATE_O(st),
      .RUN_O(run),
      .DATA_EN_O(den)
   );

   // ----------------------------------------
   // Compare tasks
   // ----------------------------------------
   task automatic miss(input string what);
      num_errors++;
      $display("wrong value at %0t: %s", $time, what);
   endtask
   task automatic check_cmd(input sdcd_cmd_t exp, input logic [1:0] exp_bank);
      total_checks++;
      if (cmd !== exp) miss("decoded command");
      if (exp != SDCD_CMD_NONE && cbank !== exp_bank) miss("command bank");
   endtask
   task automatic check_open(input logic [3:0] exp);
      total_checks++;
      if (open !== exp) miss("open bank map");
   endtask
   task automatic check_state(input sdcd_state_t exp, input logic exp_run);
      total_checks++;
      if (st !== exp || run !== exp_run) miss("state or run");
   endtask
   task automatic check_den(input logic exp);
      total_checks++;
      if (den !== exp) miss("data enable");
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Drivers
   // ----------------------------------------
   // Pins take two sync stages and one output stage, so results stand three edges on.
   task automatic send(input logic [3:0] c, input logic [1:0] b, input logic f);
      @(posedge clk);
      code <= c;
      bank <= b;
      flag <= f;
      @(posedge clk);
      code <= `SDCD_CODE_NOP;
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic set_gate(input logic g, input logic [3:0] c);
      @(posedge clk);
      gate <= g;
      code <= c;
      @(posedge clk);
      code <= `SDCD_CODE_NOP;
      repeat (2) @(posedge clk);
      #1;
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_access;
      send(`SDCD_CODE_ACT, 2'h1, 1'b0);
      check_cmd(SDCD_CMD_ACT, 2'h1);
      check_open(4'h2);
      send(`SDCD_CODE_RD, 2'h1, 1'b1);
      check_cmd(SDCD_CMD_RDA, 2'h1);
      send(`SDCD_CODE_WR, 2'h1, 1'b0);
      check_cmd(SDCD_CMD_WR, 2'h1);
      send(`SDCD_CODE_RD, 2'h2, 1'b0);
      check_cmd(SDCD_CMD_NONE, 2'h0);
      send(`SDCD_CODE_MRS, 2'h0, 1'b0);
      check_cmd(SDCD_CMD_NONE, 2'h0);
      send(4'hA, 2'h1, 1'b1);
      check_cmd(SDCD_CMD_NONE, 2'h0);
      check_open(4'h2);
   endtask
   task automatic t_mask;
      @(posedge clk);
      mask <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      check_den(1'b1);
      @(posedge clk);
      mask <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      check_den(1'b0);
   endtask
   task automatic t_burst;
      @(posedge clk);
      burst <= 1'b1;
      send(`SDCD_CODE_BST, 2'h1, 1'b0);
      check_cmd(SDCD_CMD_NONE, 2'h0);
      send(`SDCD_CODE_NOP, 2'h1, 1'b0);
      check_cmd(SDCD_CMD_NOP, 2'h1);
      check_open(4'h2);
      @(posedge clk);
      fp <= 1'b1;
      send(`SDCD_CODE_BST, 2'h1, 1'b0);
      check_cmd(SDCD_CMD_BST, 2'h1);
      @(posedge clk);
      burst <= 1'b0;
      fp <= 1'b0;
   endtask
   task automatic t_suspend;
      set_gate(1'b0, `SDCD_CODE_MRS);
      check_state(SDCD_ST_SUSPEND, 1'b0);
      check_open(4'h2);
      send(`SDCD_CODE_ACT, 2'h2, 1'b0);
      check_cmd(SDCD_CMD_NONE, 2'h0);
      check_open(4'h2);
      set_gate(1'b1, `SDCD_CODE_NOP);
      check_state(SDCD_ST_NORMAL, 1'b1);
   endtask
   task automatic t_precharge;
      send(`SDCD_CODE_ACT, 2'h3, 1'b0);
      check_open(4'hA);
      send(`SDCD_CODE_PRE, 2'h1, 1'b0);
      check_cmd(SDCD_CMD_PRE, 2'h1);
      check_open(4'h8);
      send(`SDCD_CODE_PRE, 2'h0, 1'b1);
      check_cmd(SDCD_CMD_PREALL, 2'h0);
      check_open(4'h0);
   endtask
   task automatic t_low_power;
      set_gate(1'b0, `SDCD_CODE_NOP);
      check_state(SDCD_ST_POWERDN, 1'b0);
      set_gate(1'b1, `SDCD_CODE_NOP);
      check_state(SDCD_ST_NORMAL, 1'b1);
      send(`SDCD_CODE_REF, 2'h0, 1'b0);
      check_cmd(SDCD_CMD_REF, 2'h0);
      set_gate(1'b0, `SDCD_CODE_REF);
      check_state(SDCD_ST_SELFREF, 1'b0);
      set_gate(1'b1, `SDCD_CODE_NOP);
      check_state(SDCD_ST_NORMAL, 1'b1);
      @(posedge clk);
      burst <= 1'b1;
      set_gate(1'b0, `SDCD_CODE_NOP);
      check_state(SDCD_ST_SUSPEND, 1'b0);
      set_gate(1'b1, `SDCD_CODE_NOP);
      check_state(SDCD_ST_NORMAL, 1'b1);
      @(posedge clk);
      burst <= 1'b0;
   endtask

   // ----------------------------------------
   // Sequence and watchdog
   // ----------------------------------------
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      #1;
      check_state(SDCD_ST_NORMAL, 1'b1);
      check_open(4'h0);
      check_den(1'b0);
      t_access();
      t_mask();
      t_burst();
      t_suspend();
      t_precharge();
      t_low_power();
      report_and_stop();
   end
   // The whole run needs about 110 cycles; a hang stops here.
   initial begin
      repeat (3000) @(posedge clk);
      num_errors++;
      report_and_stop();
   end
endmodule // test_sdram_command_decode
